// ===== rtl/port_stats_params.svh
// offsets, field positions, reset values and limits of the statistics bank
`ifndef PORT_STATS_PARAMS_SVH
`define PORT_STATS_PARAMS_SVH
`define NUM_PORTS          7
`define NUM_QUEUES         6
`define NO_PORT            3'h7
`define INBAND_PORT_IDX    3'h6
`define PAGE_PORT0         8'h20
`define PAGE_RSVD0         8'h26
`define PAGE_RSVD1         8'h27
`define PAGE_INBAND        8'h28
`define PAGE_CTRL          8'h70
`define OFS_CTRL           8'h00
`define CTRL_FROZEN_BIT    0
`define CTRL_QOS_BIT       1
`define CTRL_CAPTURE_BIT   2
`define CTRL_RESET         2'h0
`define OFS_TX_BYTES_LO    8'h00
`define OFS_TX_BYTES_HI    8'h04
`define OFS_TX_DROP        8'h08
`define OFS_TX_Q0          8'h0C
`define OFS_TX_BCAST       8'h10
`define OFS_TX_MCAST       8'h14
`define OFS_TX_UCAST       8'h18
`define OFS_TX_COLL        8'h1C
`define OFS_TX_ONE_COLL    8'h20
`define OFS_TX_MANY_COLL   8'h24
`define OFS_TX_DEFER       8'h28
`define OFS_TX_LATE_COLL   8'h2C
`define OFS_RSVD_SLOT      8'h30
`define OFS_QFULL_DISC     8'h34
`define OFS_TX_PAUSE       8'h38
`define OFS_TX_Q1          8'h3C
`define OFS_TX_Q2          8'h40
`define OFS_TX_Q3          8'h44
`define OFS_TX_Q4          8'h48
`define OFS_TX_Q5          8'h4C
`define OFS_RX_BYTES_LO    8'h50
`define OFS_RX_BYTES_HI    8'h54
`define OFS_RX_SHORT       8'h58
`define CNT_RESET          32'h00000000
`define BYTES_RESET        64'h0000000000000000
`define LATE_COL_BITS      16'h0200
`define SHORT_FRAME_LEN    16'h0040
`endif

// ===== rtl/port_stats_pkg.sv
// types shared by the statistics counter bank
package port_stats_pkg;
   typedef enum logic [4:0] {
      CNT_Q0       = 5'h00,
      CNT_Q1       = 5'h01,
      CNT_Q2       = 5'h02,
      CNT_Q3       = 5'h03,
      CNT_Q4       = 5'h04,
      CNT_Q5       = 5'h05,
      CNT_DROP     = 5'h06,
      CNT_BCAST    = 5'h07,
      CNT_MCAST    = 5'h08,
      CNT_UCAST    = 5'h09,
      CNT_COLL     = 5'h0A,
      CNT_ONE_COLL = 5'h0B,
      CNT_MANY_COL = 5'h0C,
      CNT_DEFER    = 5'h0D,
      CNT_LATE     = 5'h0E,
      CNT_QDISC    = 5'h0F,
      CNT_PAUSE    = 5'h10,
      CNT_SHORT    = 5'h11
   } cnt_id_t;
   localparam int NUM_CNT = 18;
   typedef enum logic [5:0] {
      WS_NONE = 6'h01,
      WS_TXLO = 6'h02,
      WS_TXHI = 6'h04,
      WS_RXLO = 6'h08,
      WS_RXHI = 6'h10,
      WS_CNT  = 6'h20
   } word_sel_t;
   typedef enum logic [1:0] {
      DEST_UNI   = 2'h0,
      DEST_MULTI = 2'h1,
      DEST_BROAD = 2'h2
   } dest_kind_t;
endpackage : port_stats_pkg

// ===== rtl/stat_counter_page.sv
// one port's counter page: live counters, frozen copy and word read mux
`timescale 1ns/1ps
`include "port_stats_params.svh"
module stat_counter_page
   import port_stats_pkg::*;
#(
   parameter int NCNT  = 18,
   parameter int LEN_W = 16
) (
   input  wire logic             core_clk,
   input  wire logic             rstn,
   input  wire logic [NCNT-1:0]  inc,
   input  wire logic             tx_add_en,
   input  wire logic [LEN_W-1:0] tx_add,
   input  wire logic             rx_add_en,
   input  wire logic [LEN_W-1:0] rx_add,
   input  wire logic             capture,
   input  wire logic             frozen_sel,
   input  wire word_sel_t        rd_sel,
   input  wire cnt_id_t          rd_id,
   output logic      [31:0]      rd_word
);
   logic [63:0] tx_bytes_r;
   logic [63:0] rx_bytes_r;
   logic [63:0] tx_frz_r;
   logic [63:0] rx_frz_r;
   logic [31:0] cnt_r [NCNT];
   logic [31:0] frz_r [NCNT];
   logic [63:0] tx_src;
   logic [63:0] rx_src;
   logic [31:0] cnt_src;

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         tx_bytes_r <= `BYTES_RESET;
      end else if (tx_add_en) begin
         tx_bytes_r <= tx_bytes_r + 64'(tx_add);
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         rx_bytes_r <= `BYTES_RESET;
      end else if (rx_add_en) begin
         rx_bytes_r <= rx_bytes_r + 64'(rx_add);
      end
   end

   for (genvar g = 0; g < NCNT; g++) begin : g_cnt
      always_ff @(posedge core_clk or negedge rstn) begin
         if (!rstn) begin
            cnt_r[g] <= `CNT_RESET;
            frz_r[g] <= `CNT_RESET;
         end else begin
            cnt_r[g] <= cnt_r[g] + 32'(inc[g]);
            if (capture) begin
               frz_r[g] <= cnt_r[g];
            end
         end
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         tx_frz_r <= `BYTES_RESET;
         rx_frz_r <= `BYTES_RESET;
      end else if (capture) begin
         tx_frz_r <= tx_bytes_r;
         rx_frz_r <= rx_bytes_r;
      end
   end

   assign tx_src  = frozen_sel ? tx_frz_r : tx_bytes_r;
   assign rx_src  = frozen_sel ? rx_frz_r : rx_bytes_r;
   assign cnt_src = frozen_sel ? frz_r[rd_id] : cnt_r[rd_id];

   always_comb begin
      unique case (rd_sel)
         WS_TXLO: rd_word = tx_src[31:0];
         WS_TXHI: rd_word = tx_src[63:32];
         WS_RXLO: rd_word = rx_src[31:0];
         WS_RXHI: rd_word = rx_src[63:32];
         WS_CNT:  rd_word = cnt_src;
         default: rd_word = 32'h00000000;
      endcase
   end
endmodule : stat_counter_page

// ===== rtl/port_traffic_statistics_counters.sv
// per-port traffic statistics bank: register slave, event qualifiers, pages
`timescale 1ns/1ps
`include "port_stats_params.svh"
module port_traffic_statistics_counters
   import port_stats_pkg::*;
#(
   parameter int LEN_W = 16
) (
   input  wire logic                                core_clk,
   input  wire logic                                rstn,
   input  wire logic [15:0]                         bus_addr,
   input  wire logic [31:0]                         bus_wdata,
   input  wire logic                                bus_wr,
   input  wire logic                                bus_rd,
   output logic      [31:0]                         bus_rdata,
   input  wire logic [`NUM_PORTS-1:0]               tx_done,
   input  wire logic [`NUM_PORTS-1:0]               tx_good,
   input  wire logic [`NUM_PORTS-1:0][LEN_W-1:0]    tx_len,
   input  wire logic [`NUM_PORTS-1:0][1:0]          tx_dest,
   input  wire logic [`NUM_PORTS-1:0][2:0]          tx_queue,
   input  wire logic [`NUM_PORTS-1:0]               tx_deferred,
   input  wire logic [`NUM_PORTS-1:0]               tx_drop,
   input  wire logic [`NUM_PORTS-1:0]               tx_mac_err,
   input  wire logic [`NUM_PORTS-1:0]               tx_collision,
   input  wire logic [`NUM_PORTS-1:0][15:0]         tx_col_bits,
   input  wire logic [`NUM_PORTS-1:0]               pause_event,
   input  wire logic [`NUM_PORTS-1:0]               queue_discard,
   input  wire logic [`NUM_PORTS-1:0]               rx_done,
   input  wire logic [`NUM_PORTS-1:0]               rx_good,
   input  wire logic [`NUM_PORTS-1:0][LEN_W-1:0]    rx_len
);
   localparam int NPORT = `NUM_PORTS;

   logic [1:0]  ctrl_r;
   logic        frozen_copy_select;
   logic        qos_en;
   logic        ctrl_hit;
   logic        capture;
   logic [7:0]  page;
   logic [7:0]  ofs;
   logic [2:0]  rd_port;
   word_sel_t   rd_sel;
   cnt_id_t     rd_id;
   logic [31:0] page_word [NPORT];
   logic [31:0] rdata_nxt;
   logic [31:0] rdata_r;

   function automatic logic [2:0] port_of_page(input logic [7:0] pg);
      if (pg >= `PAGE_PORT0 && pg < `PAGE_RSVD0) begin
         port_of_page = 3'(pg - `PAGE_PORT0);
      end else if (pg == `PAGE_INBAND) begin
         port_of_page = `INBAND_PORT_IDX;
      end else begin
         port_of_page = `NO_PORT;
      end
   endfunction : port_of_page

   // word kind within a page
   function automatic word_sel_t sel_of_ofs(input logic [7:0] o);
      unique case (o)
         `OFS_TX_BYTES_LO: sel_of_ofs = WS_TXLO;
         `OFS_TX_BYTES_HI: sel_of_ofs = WS_TXHI;
         `OFS_RX_BYTES_LO: sel_of_ofs = WS_RXLO;
         `OFS_RX_BYTES_HI: sel_of_ofs = WS_RXHI;
         `OFS_TX_DROP,
         `OFS_TX_Q0,
         `OFS_TX_BCAST,
         `OFS_TX_MCAST,
         `OFS_TX_UCAST,
         `OFS_TX_COLL,
         `OFS_TX_ONE_COLL,
         `OFS_TX_MANY_COLL,
         `OFS_TX_DEFER,
         `OFS_TX_LATE_COLL,
         `OFS_QFULL_DISC,
         `OFS_TX_PAUSE,
         `OFS_TX_Q1,
         `OFS_TX_Q2,
         `OFS_TX_Q3,
         `OFS_TX_Q4,
         `OFS_TX_Q5,
         `OFS_RX_SHORT:    sel_of_ofs = WS_CNT;
         default:          sel_of_ofs = WS_NONE;
      endcase
   endfunction : sel_of_ofs

   // counter id of a 32-bit counter word
   function automatic cnt_id_t id_of_ofs(input logic [7:0] o);
      unique case (o)
         `OFS_TX_DROP:      id_of_ofs = CNT_DROP;
         `OFS_TX_Q0:        id_of_ofs = CNT_Q0;
         `OFS_TX_BCAST:     id_of_ofs = CNT_BCAST;
         `OFS_TX_MCAST:     id_of_ofs = CNT_MCAST;
         `OFS_TX_UCAST:     id_of_ofs = CNT_UCAST;
         `OFS_TX_COLL:      id_of_ofs = CNT_COLL;
         `OFS_TX_ONE_COLL:  id_of_ofs = CNT_ONE_COLL;
         `OFS_TX_MANY_COLL: id_of_ofs = CNT_MANY_COL;
         `OFS_TX_DEFER:     id_of_ofs = CNT_DEFER;
         `OFS_TX_LATE_COLL: id_of_ofs = CNT_LATE;
         `OFS_QFULL_DISC:   id_of_ofs = CNT_QDISC;
         `OFS_TX_PAUSE:     id_of_ofs = CNT_PAUSE;
         `OFS_TX_Q1:        id_of_ofs = CNT_Q1;
         `OFS_TX_Q2:        id_of_ofs = CNT_Q2;
         `OFS_TX_Q3:        id_of_ofs = CNT_Q3;
         `OFS_TX_Q4:        id_of_ofs = CNT_Q4;
         `OFS_TX_Q5:        id_of_ofs = CNT_Q5;
         `OFS_RX_SHORT:     id_of_ofs = CNT_SHORT;
         default:           id_of_ofs = CNT_DROP;
      endcase
   endfunction : id_of_ofs

   assign page     = bus_addr[15:8];
   assign ofs      = bus_addr[7:0];
   assign ctrl_hit = (page == `PAGE_CTRL) && (ofs == `OFS_CTRL);
   assign rd_port  = port_of_page(page);
   assign rd_sel   = sel_of_ofs(ofs);
   assign rd_id    = id_of_ofs(ofs);

   assign frozen_copy_select = ctrl_r[`CTRL_FROZEN_BIT];
   assign qos_en             = ctrl_r[`CTRL_QOS_BIT];

   // control word: frozen copy select and QoS enable
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         ctrl_r <= `CTRL_RESET;
      end else if (bus_wr && ctrl_hit) begin
         ctrl_r[`CTRL_FROZEN_BIT] <= bus_wdata[`CTRL_FROZEN_BIT];
         ctrl_r[`CTRL_QOS_BIT]    <= bus_wdata[`CTRL_QOS_BIT];
      end
   end

   // snapshot taken by writing the capture bit
   assign capture = bus_wr && ctrl_hit && bus_wdata[`CTRL_CAPTURE_BIT];

   always_comb begin
      rdata_nxt = 32'h00000000;
      if (bus_rd) begin
         if (ctrl_hit) begin
            rdata_nxt = {30'h00000000, ctrl_r};
         end else if (rd_port != `NO_PORT) begin
            rdata_nxt = page_word[rd_port];
         end
      end
   end

   // read data stand only in the cycle after the strobe
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         rdata_r <= 32'h00000000;
      end else begin
         rdata_r <= rdata_nxt;
      end
   end

   assign bus_rdata = rdata_r;

   for (genvar p = 0; p < NPORT; p++) begin : g_port
      logic [NUM_CNT-1:0] inc;
      logic [1:0]         coll_r;
      logic               tx_ok;
      logic               late;
      logic               rx_short;
      logic [31:0]        word;

      assign tx_ok = tx_done[p] & tx_good[p];

      assign late = tx_collision[p] && (tx_col_bits[p] > `LATE_COL_BITS);

      assign rx_short = rx_done[p] && rx_good[p] && (16'(rx_len[p]) < `SHORT_FRAME_LEN);

      // collisions seen by the frame in flight, saturating at two
      always_ff @(posedge core_clk or negedge rstn) begin
         if (!rstn) begin
            coll_r <= 2'h0;
         end else if (tx_done[p]) begin
            coll_r <= 2'h0;
         end else if (tx_collision[p] && coll_r != 2'h2) begin
            coll_r <= coll_r + 2'h1;
         end
      end

      always_comb begin
         inc = '0;
         inc[CNT_DROP] = tx_drop[p] | (tx_mac_err[p] & ~late);
         if (tx_ok && qos_en && tx_queue[p] < 3'(`NUM_QUEUES)) begin
            inc[5'(tx_queue[p])] = 1'b1;
         end
         inc[CNT_BCAST] = tx_ok && (tx_dest[p] == DEST_BROAD);
         inc[CNT_MCAST] = tx_ok && (tx_dest[p] == DEST_MULTI);
         inc[CNT_UCAST] = tx_ok && (tx_dest[p] == DEST_UNI);
         inc[CNT_COLL] = tx_collision[p];
         inc[CNT_ONE_COLL] = tx_ok && (coll_r == 2'h1);
         inc[CNT_MANY_COL] = tx_ok && (coll_r == 2'h2);
         inc[CNT_DEFER] = tx_ok && tx_deferred[p];
         inc[CNT_LATE] = late;
         inc[CNT_QDISC] = queue_discard[p];
         inc[CNT_PAUSE] = pause_event[p];
         inc[CNT_SHORT] = rx_short;
      end

      stat_counter_page #(
         .NCNT  (NUM_CNT),
         .LEN_W (LEN_W)
      ) u_page (
         .core_clk   (core_clk),
         .rstn       (rstn),
         .inc        (inc),
         .tx_add_en  (tx_ok),
         .tx_add     (tx_len[p]),
         .rx_add_en  (rx_done[p]),
         .rx_add     (rx_len[p]),
         .capture    (capture),
         .frozen_sel (frozen_copy_select),
         .rd_sel     (rd_sel),
         .rd_id      (rd_id),
         .rd_word    (word)
      );

      assign page_word[p] = word;
   end
endmodule : port_traffic_statistics_counters

// ===== tb/port_stats_chk.sv
// concurrent checks on the statistics bank register port and counters
`timescale 1ns/1ps
`include "port_stats_params.svh"
module port_stats_chk
   import port_stats_pkg::*;
(
   input wire logic                          core_clk,
   input wire logic                          rstn,
   input wire logic [15:0]                   bus_addr,
   input wire logic [31:0]                   bus_wdata,
   input wire logic                          bus_wr,
   input wire logic                          bus_rd,
   input wire logic [31:0]                   bus_rdata,
   input wire logic [`NUM_PORTS-1:0]         tx_done,
   input wire logic [`NUM_PORTS-1:0]         tx_good,
   input wire logic [`NUM_PORTS-1:0][1:0]    tx_dest,
   input wire logic [`NUM_PORTS-1:0]         tx_drop,
   input wire logic [`NUM_PORTS-1:0]         tx_mac_err,
   input wire logic [`NUM_PORTS-1:0]         tx_collision,
   input wire logic [`NUM_PORTS-1:0]         pause_event,
   input wire logic [`NUM_PORTS-1:0]         queue_discard,
   input wire logic [`NUM_PORTS-1:0]         rx_done
);
   logic frz_r;
   logic quiet;
   logic cnt_page;
   assign quiet = ~|{tx_done, tx_drop, tx_mac_err, tx_collision, pause_event, queue_discard,
                     rx_done};
   assign cnt_page = bus_addr[15:8] inside {[8'h20:8'h28]};
   // mirror of the frozen view select bit
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         frz_r <= 1'h0;
      end else if (bus_wr && bus_addr == 16'h7000) begin
         frz_r <= bus_wdata[`CTRL_FROZEN_BIT];
      end
   end
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rstn);
   sequence s_rd_live(a, ev);
      bus_rd && bus_addr == a && ev && !frz_r;
   endsequence
   sequence s_rd_again;
      bus_rd && $stable(bus_addr);
   endsequence
   sequence s_rd_wr_rd;
      (bus_rd && cnt_page && quiet) ##1 (bus_wr && $stable(bus_addr) && quiet) ##1 s_rd_again;
   endsequence
   property p_step(a, ev);
      s_rd_live(a, ev) ##1 s_rd_again |=> bus_rdata == $past(bus_rdata) + 32'h1;
   endproperty
   a_rd_idle_zero:
      assert property (!bus_rd |=> bus_rdata == 32'h0) else $error("read data not idle");
   a_rsvd_page_zero:
      assert property (bus_rd && bus_addr[15:8] inside {8'h26, 8'h27} |=> bus_rdata == 32'h0)
      else $error("reserved page read not zero");
   a_rsvd_slot_zero:
      assert property (bus_rd && cnt_page && bus_addr[7:0] == `OFS_RSVD_SLOT
                       |=> bus_rdata == 32'h0) else $error("reserved slot read not zero");
   a_ro_hold:
      assert property (s_rd_wr_rd |=> bus_rdata == $past(bus_rdata, 2))
      else $error("counter changed by write");
   a_drop_step:
      assert property (p_step(16'h2008, tx_drop[0])) else $error("drop count step wrong");
   a_bcast_step:
      assert property (p_step(16'h2010, tx_done[0] && tx_good[0] && tx_dest[0] == 2'h2))
      else $error("broadcast count step wrong");
   a_coll_step:
      assert property (p_step(16'h201C, tx_collision[0])) else $error("collision step wrong");
   a_pause_step:
      assert property (p_step(16'h2038, pause_event[0])) else $error("pause step wrong");
   a_frozen_hold:
      assert property (frz_r && bus_rd ##1 s_rd_again |=> $stable(bus_rdata))
      else $error("frozen view moved");
endmodule : port_stats_chk
bind port_traffic_statistics_counters port_stats_chk port_stats_chk_inst (
   .core_clk(core_clk), .rstn(rstn), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
   .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .tx_done(tx_done),
   .tx_good(tx_good), .tx_dest(tx_dest), .tx_drop(tx_drop), .tx_mac_err(tx_mac_err),
   .tx_collision(tx_collision), .pause_event(pause_event), .queue_discard(queue_discard),
   .rx_done(rx_done));

// ===== tb/tb_top.sv
// self-checking bench for the port statistics counter bank
`timescale 1ns/1ps
`include "port_stats_params.svh"
module tb_top
   import port_stats_pkg::*;
;
   logic                          core_clk = 1'h0;
   logic                          rstn;
   logic [15:0]                   bus_addr;
   logic [31:0]                   bus_wdata;
   logic [31:0]                   bus_rdata;
   logic                          bus_wr;
   logic                          bus_rd;
   logic [`NUM_PORTS-1:0]         tx_done, tx_good, tx_deferred, tx_drop, tx_mac_err;
   logic [`NUM_PORTS-1:0]         tx_collision, pause_event, queue_discard, rx_done, rx_good;
   logic [`NUM_PORTS-1:0][15:0]   tx_len, tx_col_bits, rx_len;
   logic [`NUM_PORTS-1:0][1:0]    tx_dest;
   logic [`NUM_PORTS-1:0][2:0]    tx_queue;
   logic [31:0]                   v0, v1;
   logic [7:0]                    qofs [6] = '{8'h0C, 8'h3C, 8'h40, 8'h44, 8'h48, 8'h4C};
   logic [7:0]                    sofs [4] = '{8'h08, 8'h10, 8'h1C, 8'h38};
   int                            errors = 0;
   int                            tests_run = 0;
   int                            cyc = 0;
   always #25 core_clk = ~core_clk;
   port_traffic_statistics_counters #(.LEN_W(16)) port_traffic_statistics_counters_inst (
      .core_clk(core_clk), .rstn(rstn), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
      .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .tx_done(tx_done),
      .tx_good(tx_good), .tx_len(tx_len), .tx_dest(tx_dest), .tx_queue(tx_queue),
      .tx_deferred(tx_deferred), .tx_drop(tx_drop), .tx_mac_err(tx_mac_err),
      .tx_collision(tx_collision), .tx_col_bits(tx_col_bits), .pause_event(pause_event),
      .queue_discard(queue_discard), .rx_done(rx_done), .rx_good(rx_good), .rx_len(rx_len));
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : wrap_up
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         errors++;
         wrap_up();
      end
   end
   task automatic clr;
      tx_done <= '0;
      tx_drop <= '0;
      tx_mac_err <= '0;
      tx_collision <= '0;
      pause_event <= '0;
      queue_discard <= '0;
      rx_done <= '0;
   endtask : clr
   // one event cycle, then a quiet cycle
   task automatic pl;
      @(posedge core_clk);
      clr();
      @(posedge core_clk);
   endtask : pl
   task automatic wr(input logic [15:0] a, input logic [31:0] d);
      bus_addr <= a;
      bus_wdata <= d;
      bus_wr <= 1'h1;
      @(posedge core_clk);
      bus_wr <= 1'h0;
      @(posedge core_clk);
   endtask : wr
   // two reads of one address, back to back or with a write between
   task automatic rd2(input logic [15:0] a, input logic mid, output logic [31:0] r0, r1);
      bus_addr <= a;
      bus_wdata <= 32'hFFFFFFFF;
      bus_rd <= 1'h1;
      @(posedge core_clk);
      clr();
      if (mid) begin
         bus_rd <= 1'h0;
         bus_wr <= 1'h1;
      end
      #1 r0 = bus_rdata;
      if (mid) begin
         @(posedge core_clk);
         bus_wr <= 1'h0;
         bus_rd <= 1'h1;
      end
      @(posedge core_clk);
      bus_rd <= 1'h0;
      #1 r1 = bus_rdata;
      @(posedge core_clk);
   endtask : rd2
   task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         errors++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask : cmp
   task automatic ck(input logic [15:0] a, input logic [31:0] exp);
      rd2(a, 1'h0, v0, v1);
      cmp($sformatf("addr %h", a), exp, v1);
   endtask : ck
   function automatic logic [7:0] pg(input int i);
      return (i < 6) ? 8'h20 + 8'(i) : `PAGE_INBAND;
   endfunction : pg
   initial begin
      rstn <= 1'h0;
      {bus_addr, bus_wdata, bus_wr, bus_rd, tx_good, tx_deferred, rx_good} <= '0;
      {tx_len, tx_col_bits, rx_len, tx_dest, tx_queue} <= '0;
      clr();
      repeat (20) @(posedge core_clk);
      rstn <= 1'h1;
      @(posedge core_clk);
      for (int p = 0; p < 9; p++) ck({8'h20 + 8'(p), `OFS_TX_DROP}, 32'h0);
      ck(16'h2030, 32'h0);
      ck(16'h9900, 32'h0);
      $display("test reset done");
      for (int i = 0; i < 7; i++) begin
         repeat (i + 1) begin
            pause_event[i] <= 1'h1;
            pl();
         end
      end
      for (int i = 0; i < 7; i++) ck({pg(i), `OFS_TX_PAUSE}, 32'(i + 1));
      ck(16'h2638, 32'h0);
      ck(16'h2738, 32'h0);
      $display("test ports done");
      for (int k = 0; k < 4; k++) begin
         case (k)
            0: tx_drop[0] <= 1'h1;
            1: begin
               {tx_done[0], tx_good[0], tx_dest[0], tx_len[0]} <= {2'h3, 2'h2, 16'h0040};
            end
            2: begin
               {tx_collision[0], tx_col_bits[0]} <= {1'h1, 16'h0010};
            end
            default: pause_event[0] <= 1'h1;
         endcase
         rd2({8'h20, sofs[k]}, 1'h0, v0, v1);
         cmp("step", v0 + 32'h1, v1);
      end
      wr(16'h7000, 32'h5);
      ck(16'h7000, 32'h1);
      pause_event[0] <= 1'h1;
      rd2(16'h2038, 1'h0, v0, v1);
      cmp("frozen first", 32'h2, v0);
      cmp("frozen second", 32'h2, v1);
      wr(16'h7000, 32'h0);
      ck(16'h2038, 32'h3);
      $display("test steps done");
      tx_deferred[2] <= 1'h1;
      for (int d = 0; d < 5; d++) begin
         {tx_done[2], tx_good[2], tx_dest[2], tx_len[2]} <= {1'h1, d < 4, 2'(d), 16'h0040};
         pl();
      end
      ck(16'h2200, 32'h100);
      ck(16'h2204, 32'h0);
      ck(16'h2210, 32'h1);
      ck(16'h2214, 32'h1);
      ck(16'h2218, 32'h1);
      ck(16'h2228, 32'h4);
      ck(16'h220C, 32'h0);
      wr(16'h7000, 32'h2);
      ck(16'h7000, 32'h2);
      for (int q = 0; q < 7; q++) begin
         {tx_done[2], tx_good[2], tx_dest[2], tx_queue[2]} <= {2'h3, 2'h3, 3'(q)};
         pl();
      end
      for (int q = 0; q < 6; q++) ck({8'h22, qofs[q]}, 32'h1);
      ck(16'h2200, 32'h2C0);
      ck(16'h2228, 32'hB);
      ck(16'h2208, 32'h0);
      wr(16'h7000, 32'h0);
      $display("test frames done");
      {tx_collision[3], tx_col_bits[3]} <= {1'h1, 16'h0064};
      pl();
      {tx_done[3], tx_good[3]} <= 2'h3;
      pl();
      {tx_collision[3], tx_col_bits[3]} <= {1'h1, `LATE_COL_BITS};
      pl();
      {tx_collision[3], tx_col_bits[3], tx_mac_err[3]} <= {1'h1, 16'h0258, 1'h1};
      pl();
      tx_done[3] <= 1'h1;
      pl();
      tx_drop[3] <= 1'h1;
      pl();
      tx_mac_err[3] <= 1'h1;
      pl();
      ck(16'h231C, 32'h3);
      ck(16'h2320, 32'h1);
      ck(16'h2324, 32'h1);
      ck(16'h232C, 32'h1);
      ck(16'h2308, 32'h2);
      $display("test collisions done");
      {rx_done[4], rx_good[4], rx_len[4]} <= {2'h3, 16'h003F};
      pl();
      {rx_done[4], rx_len[4]} <= {1'h1, `SHORT_FRAME_LEN};
      pl();
      {rx_done[4], rx_good[4], rx_len[4]} <= {2'h2, 16'h0014};
      pl();
      repeat (2) begin
         queue_discard[4] <= 1'h1;
         pl();
      end
      ck(16'h2450, 32'h93);
      ck(16'h2454, 32'h0);
      ck(16'h2458, 32'h1);
      ck(16'h2434, 32'h2);
      $display("test receive done");
      rd2(16'h2308, 1'h1, v0, v1);
      cmp("write guard first", 32'h2, v0);
      cmp("write guard second", 32'h2, v1);
      $display("test readonly done");
      wrap_up();
   end
endmodule : tb_top
